// ===== hdl/sld_lcd_driver.sv
/*
  Segment LCD driver: AXI4-Lite registers, display RAM, 60 x 16 panel scan.
  Assumes a 250 MHz clock, an asynchronous active-low reset from outside,
  and an analog stage that turns select levels, polarity and voltage code
  into real electrode waveforms.
*/
`include "sld_defines.svh"
`default_nettype none

module sld_lcd_driver (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // AXI4-Lite write address
  input  wire logic [7:0]  i_s_axi_awaddr,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  i_s_axi_araddr,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  // Panel electrodes (select levels)
  output logic [59:0]      o_front_electrode,
  output logic [15:0]      o_backplane_line,
  output logic [15:0]      o_backplane_open,
  // Analog stage controls
  output logic             o_frame_polarity,
  output logic             o_panel_drive_en,
  output logic [2:0]       o_drive_voltage
);
  import sld_pkg::*;

  // Reset synchroniser
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // Registers and display RAM
  logic [2:0]  ctl;
  logic [6:0]  ram_index;
  logic [2:0]  vsel;
  logic [7:0]  ram [`SLD_RAM_DEPTH];
  sld_panel_t  panel;
  sld_duty_t   duty_active;
  logic        disp_off;
  logic        disp_blank;
  logic        run;

  assign panel      = sld_panel_t'(ctl[`SLD_CTL_STATE_HI:`SLD_CTL_STATE_LO]);
  // The undefined 10 code is treated as off
  assign disp_off   = (panel == SLD_PANEL_OFF) || (panel == SLD_PANEL_ODD);
  assign disp_blank = (panel == SLD_PANEL_BLANK);
  assign run        = !disp_off;

  // Dot lookup shared by scan and any future readback path
  function automatic logic seg_dot(input logic [5:0] seg, input logic [3:0] com);
    logic [6:0] addr;
    addr = com[3] ? (`SLD_HIGH_BANK + 7'(seg)) : 7'(seg);
    return ram[addr][com[2:0]];
  endfunction : seg_dot

  // Write channel
  logic        aw_got;
  logic        w_got;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic        wr_lane0;
  logic        wr_fire;

  assign wr_fire = aw_got && w_got && !o_s_axi_bvalid;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got          <= 1'b0;
      wr_addr         <= 8'h00;
      o_s_axi_awready <= 1'b0;
    end else if (i_s_axi_awvalid && o_s_axi_awready) begin
      aw_got          <= 1'b1;
      wr_addr         <= i_s_axi_awaddr;
      o_s_axi_awready <= 1'b0;
    end else begin
      if (wr_fire) begin
        aw_got <= 1'b0;
      end
      if (!aw_got && !o_s_axi_bvalid) begin
        o_s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_got          <= 1'b0;
      wr_data        <= 8'h00;
      wr_lane0       <= 1'b0;
      o_s_axi_wready <= 1'b0;
    end else if (i_s_axi_wvalid && o_s_axi_wready) begin
      w_got          <= 1'b1;
      wr_data        <= i_s_axi_wdata[7:0];
      wr_lane0       <= i_s_axi_wstrb[0];
      o_s_axi_wready <= 1'b0;
    end else begin
      if (wr_fire) begin
        w_got <= 1'b0;
      end
      if (!w_got && !o_s_axi_bvalid) begin
        o_s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp  <= `SLD_RESP_OKAY;
    end else if (wr_fire) begin
      o_s_axi_bvalid <= 1'b1;
      if (wr_addr == `SLD_OFS_CTL || wr_addr == `SLD_OFS_INDEX ||
          wr_addr == `SLD_OFS_VALUE || wr_addr == `SLD_OFS_VSEL) begin
        o_s_axi_bresp <= `SLD_RESP_OKAY;
      end else begin
        o_s_axi_bresp <= `SLD_RESP_SLVERR;
      end
    end else if (i_s_axi_bready) begin
      o_s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes; only byte lane 0 carries register data
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl       <= `SLD_CTL_RST;
      ram_index <= `SLD_INDEX_RST;
      vsel      <= `SLD_VSEL_RST;
    end else if (wr_fire && wr_lane0) begin
      if (wr_addr == `SLD_OFS_CTL) begin
        ctl <= wr_data[`SLD_CTL_STATE_HI:0];
      end else if (wr_addr == `SLD_OFS_INDEX) begin
        ram_index <= wr_data[`SLD_INDEX_HI:0];
      end else if (wr_addr == `SLD_OFS_VSEL) begin
        vsel <= wr_data[`SLD_VSEL_HI:`SLD_VSEL_LO];
      end
    end
  end

  // RAM writes are accepted in every panel state
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `SLD_RAM_DEPTH; i++) begin
        ram[i] <= `SLD_RAM_RST;
      end
    end else if (wr_fire && wr_lane0 && wr_addr == `SLD_OFS_VALUE) begin
      ram[ram_index] <= wr_data;
    end
  end

  // Read channel
  logic [31:0] rd_word;
  logic [1:0]  rd_resp;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_resp = `SLD_RESP_OKAY;
    if (i_s_axi_araddr == `SLD_OFS_CTL) begin
      rd_word[`SLD_CTL_STATE_HI:0] = ctl;
    end else if (i_s_axi_araddr == `SLD_OFS_INDEX) begin
      rd_word[`SLD_INDEX_HI:0] = ram_index;
    end else if (i_s_axi_araddr == `SLD_OFS_VALUE) begin
      // Scan owns the RAM while displaying, so reads see zero then
      if (disp_off) begin
        rd_word[7:0] = ram[ram_index];
      end
    end else if (i_s_axi_araddr == `SLD_OFS_VSEL) begin
      rd_word[`SLD_VSEL_HI:`SLD_VSEL_LO] = vsel;
    end else begin
      rd_resp = `SLD_RESP_SLVERR;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= 32'h0000_0000;
      o_s_axi_rresp   <= `SLD_RESP_OKAY;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid  <= 1'b1;
      o_s_axi_rdata   <= rd_word;
      o_s_axi_rresp   <= rd_resp;
    end else if (o_s_axi_rvalid) begin
      if (i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
      end
    end else begin
      o_s_axi_arready <= 1'b1;
    end
  end

  // Duty takes effect only while off, so a live frame never changes shape
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      duty_active <= SLD_DUTY_SIXTEENTH;
    end else if (disp_off) begin
      duty_active <= sld_duty_t'(ctl[`SLD_CTL_DUTY_BIT]);
    end
  end

  // Scan timing
  logic       slot_start;
  logic [3:0] com_idx;
  logic       polarity;

  sld_scan_timer u_timer (
    .i_clk        (i_clk),
    .i_rst_n      (rst_n),
    .i_run        (run),
    .i_duty       (duty_active),
    .o_slot_start (slot_start),
    .o_com_idx    (com_idx),
    .o_polarity   (polarity)
  );

  // Common outputs, panel enable and voltage code
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_backplane_line <= 16'h0000;
      o_backplane_open <= 16'h0000;
      o_frame_polarity <= 1'b0;
      o_panel_drive_en <= 1'b0;
      o_drive_voltage  <= `SLD_VSEL_RST;
    end else begin
      o_drive_voltage  <= vsel;
      o_panel_drive_en <= run;
      o_backplane_open <= (duty_active == SLD_DUTY_EIGHTH) ?
                          `SLD_OPEN_EIGHTH : 16'h0000;
      if (!run) begin
        o_backplane_line <= 16'h0000;
        o_frame_polarity <= 1'b0;
      end else if (slot_start) begin
        o_backplane_line <= 16'h0001 << com_idx;
        o_frame_polarity <= polarity;
      end
    end
  end

  // Segment outputs, one per front electrode
  for (genvar n = 0; n < `SLD_NUM_SEG; n++) begin : g_seg
    always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
        o_front_electrode[n] <= 1'b0;
      end else if (!run || disp_blank) begin
        o_front_electrode[n] <= 1'b0;
      end else if (slot_start) begin
        o_front_electrode[n] <= seg_dot(6'(n), com_idx);
      end
    end
  end

endmodule : sld_lcd_driver

`default_nettype wire

// ===== shared/sld_defines.svh
/*
  Offsets, field positions, reset values and timing counts of the segment LCD driver.
  Assumes inclusion by bare name from design files.
*/
`ifndef SLD_DEFINES_SVH
`define SLD_DEFINES_SVH

// Register byte offsets on the AXI4-Lite slave
`define SLD_OFS_CTL        8'h00
`define SLD_OFS_INDEX      8'h04
`define SLD_OFS_VALUE      8'h08
`define SLD_OFS_VSEL       8'h0C

// Field positions
`define SLD_CTL_DUTY_BIT   0
`define SLD_CTL_STATE_LO   1
`define SLD_CTL_STATE_HI   2
`define SLD_VSEL_LO        2
`define SLD_VSEL_HI        4
`define SLD_INDEX_HI       6

// Reset values
`define SLD_CTL_RST        3'h0
`define SLD_INDEX_RST      7'h00
`define SLD_VSEL_RST       3'h0
`define SLD_RAM_RST        8'h00

// Panel geometry
`define SLD_NUM_SEG        60
`define SLD_NUM_COM        16
`define SLD_RAM_DEPTH      128
`define SLD_HIGH_BANK      7'h40
`define SLD_OPEN_EIGHTH    16'hFF00

// Timing: base clock made from the system clock by a phase accumulator
`define SLD_CLK_HZ         250000000
`define SLD_BASE_HZ        32768
`define SLD_NCO_INC        (((64'(`SLD_BASE_HZ)) << 32) / 64'(`SLD_CLK_HZ))
`define SLD_SLOT_TICKS     5'd16

// AXI responses
`define SLD_RESP_OKAY      2'h0
`define SLD_RESP_SLVERR    2'h2

`endif

// ===== shared/sld_pkg.sv
/*
  Types of the segment LCD driver.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package sld_pkg;

  // Decoded panel state field
  typedef enum logic [1:0] {
    SLD_PANEL_OFF,
    SLD_PANEL_BLANK,
    SLD_PANEL_ODD,
    SLD_PANEL_ON
  } sld_panel_t;

  // Scan duty
  typedef enum logic {
    SLD_DUTY_SIXTEENTH,
    SLD_DUTY_EIGHTH
  } sld_duty_t;

endpackage : sld_pkg

`default_nettype wire

// ===== hdl/sld_scan_timer.sv
/*
  Scan timer: 32.768 kHz base tick, common slot pacing, frame polarity.
  Assumes one system clock and a synchronised active-low reset.
*/
`include "sld_defines.svh"
`default_nettype none

module sld_scan_timer (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // Control
  input  wire logic              i_run,
  input  wire sld_pkg::sld_duty_t i_duty,
  // Scan
  output logic                   o_slot_start,
  output logic [3:0]             o_com_idx,
  output logic                   o_polarity
);
  import sld_pkg::*;

  localparam logic [31:0] NCO_INC = 32'(`SLD_NCO_INC);

  logic [31:0] acc;
  logic [32:0] next_acc;
  logic        base_tick;
  logic [4:0]  tick_cnt;
  logic [3:0]  last_com;

  assign next_acc = {1'b0, acc} + {1'b0, NCO_INC};
  assign last_com = (i_duty == SLD_DUTY_EIGHTH) ? 4'h7 : 4'hF;

  // Fractional divider; the truncated increment keeps the long-run base rate just below 32768 Hz
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc       <= 32'h0000_0000;
      base_tick <= 1'b0;
    end else begin
      acc       <= next_acc[31:0];
      base_tick <= next_acc[32];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt     <= 5'h00;
      o_slot_start <= 1'b0;
    end else if (!i_run) begin
      tick_cnt     <= 5'h00;
      o_slot_start <= 1'b0;
    end else begin
      o_slot_start <= 1'b0;
      if (base_tick) begin
        if (tick_cnt == `SLD_SLOT_TICKS - 5'd1) begin
          tick_cnt     <= 5'h00;
          o_slot_start <= 1'b1;
        end else begin
          tick_cnt <= tick_cnt + 5'd1;
        end
      end
    end
  end

  // Frame ends after the last scanned common; polarity flips for AC drive
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_com_idx  <= 4'h0;
      o_polarity <= 1'b0;
    end else if (!i_run) begin
      o_com_idx  <= 4'h0;
      o_polarity <= 1'b0;
    end else if (o_slot_start) begin
      if (o_com_idx >= last_com) begin
        o_com_idx  <= 4'h0;
        o_polarity <= ~o_polarity;
      end else begin
        o_com_idx <= o_com_idx + 4'h1;
      end
    end
  end

endmodule : sld_scan_timer

`default_nettype wire

// ===== tb/sld_lcd_driver_monitor.sv
/* Checker of the segment LCD driver ports.
   Assumes binding to every sld_lcd_driver instance. */
`default_nettype none
module sld_lcd_driver_monitor (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  // Bus
  input wire logic        i_s_axi_awvalid,
  input wire logic        o_s_axi_awready,
  input wire logic        i_s_axi_wvalid,
  input wire logic        o_s_axi_wready,
  input wire logic [1:0]  o_s_axi_bresp,
  input wire logic        o_s_axi_bvalid,
  input wire logic        i_s_axi_bready,
  input wire logic        i_s_axi_arvalid,
  input wire logic        o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic        o_s_axi_rvalid,
  input wire logic        i_s_axi_rready,
  // Panel
  input wire logic [59:0] o_front_electrode,
  input wire logic [15:0] o_backplane_line,
  input wire logic [15:0] o_backplane_open,
  input wire logic        o_panel_drive_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_aw; i_s_axi_awvalid && o_s_axi_awready; endsequence
  sequence s_w; i_s_axi_wvalid && o_s_axi_wready; endsequence
  sequence s_ar; i_s_axi_arvalid && o_s_axi_arready; endsequence
  // Both parts are held one cycle before the response is launched
  a_write_answer: assert property ((s_aw and s_w) |-> ##2 o_s_axi_bvalid)
    else $error("no write response after both handshakes");
  a_read_answer: assert property (s_ar |=> o_s_axi_rvalid)
    else $error("no read data one cycle after address");
  a_bresp_stands: assert property (o_s_axi_bvalid && !i_s_axi_bready
    |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_stands: assert property (o_s_axi_rvalid && !i_s_axi_rready
    |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read data dropped early");
  a_upper_zero: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_off_dark: assert property (!o_panel_drive_en && !$past(o_panel_drive_en)
    |-> o_backplane_line == 16'h0000 && o_front_electrode == 60'h0)
    else $error("electrodes driven while off");
  a_open_code: assert property (o_backplane_open == 16'h0000
    || o_backplane_open == 16'hff00)
    else $error("bad open pattern");
  a_open_quiet: assert property (o_backplane_open[8] |-> o_backplane_line[15:8] == 8'h00)
    else $error("open common driven");
  a_one_common: assert property ($onehot0(o_backplane_line))
    else $error("more than one common active");
endmodule : sld_lcd_driver_monitor
bind sld_lcd_driver sld_lcd_driver_monitor mon (.*);
`default_nettype wire

// ===== tb/sld_panel_model.sv
/* Passive glass: flags drive on open commons.
   Assumes select levels at the ports; no analog waveforms. */
`default_nettype none
module sld_panel_model (
  // Clock
  input wire logic        i_clk,
  // Electrodes
  input wire logic [59:0] i_seg,
  input wire logic [15:0] i_com,
  input wire logic [15:0] i_open,
  // Result
  output logic            o_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  logic fault_seen = 1'b0;
  assign o_fault = fault_seen;
  // Open commons must stay undriven; segments must stay low while no common is driven
  always @(posedge i_clk) begin
    if ((i_com & i_open) != 16'h0000) fault_seen <= 1'b1;
    if (i_com == 16'h0000 && i_seg != 60'h0) fault_seen <= 1'b1;
  end
endmodule : sld_panel_model
`default_nettype wire

// ===== tb/sld_lcd_driver_test.sv
/* Bench of the segment LCD driver: register scenarios, idle panel.
   Assumes the driver, checker and panel model compiled first. */
`include "sld_defines.svh"
`default_nettype none
module sld_lcd_driver_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk, i_reset_n, fault;
  logic [7:0]  i_s_axi_awaddr, i_s_axi_araddr;
  logic [31:0] i_s_axi_wdata, o_s_axi_rdata;
  logic [3:0]  i_s_axi_wstrb;
  logic        i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready;
  logic        i_s_axi_arvalid, i_s_axi_rready;
  logic        o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
  logic        o_s_axi_arready, o_s_axi_rvalid;
  logic [1:0]  o_s_axi_bresp, o_s_axi_rresp;
  logic [59:0] o_front_electrode;
  logic [15:0] o_backplane_line, o_backplane_open;
  logic        o_frame_polarity, o_panel_drive_en;
  logic [2:0]  o_drive_voltage;
  int          n_errors = 0;
  int          n_checks = 0;
  sld_lcd_driver DUT (.*);
  sld_panel_model panel (.i_clk(i_clk), .i_seg(o_front_electrode),
    .i_com(o_backplane_line), .i_open(o_backplane_open), .o_fault(fault));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic hung;
    n_errors++;
    $display("ERROR %0t bus wait ran out", $time);
    complete_run();
  endtask : hung
  // Bready held from the start; released only after bvalid is seen
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= {24'h00_0000, d};
    i_s_axi_wstrb <= s;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    for (int k = 0; k < 64; k++) begin
      @(posedge i_clk);
      if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
      if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
      if (o_s_axi_bvalid) begin
        r = o_s_axi_bresp;
        i_s_axi_bready <= 1'b0;
        @(posedge i_clk);
        return;
      end
    end
    hung();
  endtask : wr
  task automatic rck(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    for (int k = 0; k < 64; k++) begin
      @(posedge i_clk);
      if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
      if (o_s_axi_rvalid) begin
        chk(o_s_axi_rdata, e);
        chk(32'(o_s_axi_rresp), 32'(er));
        i_s_axi_rready <= 1'b0;
        @(posedge i_clk);
        return;
      end
    end
    hung();
  endtask : rck
  task automatic wok(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, 4'hf, r);
    chk(32'(r), 32'(`SLD_RESP_OKAY));
  endtask : wok
  task automatic t_reset;
    rck(`SLD_OFS_CTL, 32'h0000_0000, `SLD_RESP_OKAY);
    rck(`SLD_OFS_INDEX, 32'h0000_0000, `SLD_RESP_OKAY);
    rck(`SLD_OFS_VALUE, 32'h0000_0000, `SLD_RESP_OKAY);
    rck(`SLD_OFS_VSEL, 32'h0000_0000, `SLD_RESP_OKAY);
    chk(32'(o_panel_drive_en), 32'h0000_0000);
    chk(32'(o_backplane_line), 32'h0000_0000);
    chk(32'(o_frame_polarity), 32'h0000_0000);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_fields;
    wok(`SLD_OFS_CTL, 8'hf9);
    rck(`SLD_OFS_CTL, 32'h0000_0001, `SLD_RESP_OKAY);
    chk(32'(o_backplane_open), 32'h0000_ff00);
    wok(`SLD_OFS_CTL, 8'h00);
    rck(`SLD_OFS_CTL, 32'h0000_0000, `SLD_RESP_OKAY);
    chk(32'(o_backplane_open), 32'h0000_0000);
    wok(`SLD_OFS_INDEX, 8'hff);
    rck(`SLD_OFS_INDEX, 32'h0000_007f, `SLD_RESP_OKAY);
    for (int v = 0; v < 8; v++) begin
      wok(`SLD_OFS_VSEL, 8'he3 | 8'(v << 2));
      rck(`SLD_OFS_VSEL, 32'(v << 2), `SLD_RESP_OKAY);
      chk(32'(o_drive_voltage), 32'(v));
    end
    $display("t_fields done");
  endtask : t_fields
  task automatic t_ram;
    logic [1:0] r;
    wok(`SLD_OFS_INDEX, 8'h3b);
    wok(`SLD_OFS_VALUE, 8'ha5);
    rck(`SLD_OFS_VALUE, 32'h0000_00a5, `SLD_RESP_OKAY);
    wr(`SLD_OFS_VALUE, 8'h5a, 4'h0, r);
    chk(32'(r), 32'(`SLD_RESP_OKAY));
    rck(`SLD_OFS_VALUE, 32'h0000_00a5, `SLD_RESP_OKAY);
    wok(`SLD_OFS_CTL, 8'h02);
    chk(32'(o_panel_drive_en), 32'h0000_0001);
    chk(32'(o_front_electrode != 60'h0), 32'h0000_0000);
    rck(`SLD_OFS_VALUE, 32'h0000_0000, `SLD_RESP_OKAY);
    wok(`SLD_OFS_INDEX, 8'h7b);
    wok(`SLD_OFS_VALUE, 8'h3c);
    wok(`SLD_OFS_CTL, 8'h06);
    chk(32'(o_panel_drive_en), 32'h0000_0001);
    rck(`SLD_OFS_VALUE, 32'h0000_0000, `SLD_RESP_OKAY);
    // Duty bit written while displaying must not reach the scan
    wok(`SLD_OFS_CTL, 8'h07);
    chk(32'(o_backplane_open), 32'h0000_0000);
    wok(`SLD_OFS_CTL, 8'h04);
    chk(32'(o_panel_drive_en), 32'h0000_0000);
    rck(`SLD_OFS_VALUE, 32'h0000_003c, `SLD_RESP_OKAY);
    wok(`SLD_OFS_CTL, 8'h00);
    rck(`SLD_OFS_VALUE, 32'h0000_003c, `SLD_RESP_OKAY);
    wr(8'h10, 8'h55, 4'hf, r);
    chk(32'(r), 32'(`SLD_RESP_SLVERR));
    rck(8'h10, 32'h0000_0000, `SLD_RESP_SLVERR);
    chk(32'(fault), 32'h0000_0000);
    $display("t_ram done");
  endtask : t_ram
  initial begin
    i_reset_n = 1'b0;
    {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} = 3'h0;
    {i_s_axi_arvalid, i_s_axi_rready} = 2'h0;
    {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wstrb} = 20'h0_0000;
    i_s_axi_wdata = 32'h0000_0000;
    repeat (10) @(posedge i_clk);
    i_reset_n <= 1'b1;
    t_reset();
    t_fields();
    t_ram();
    complete_run();
  end
endmodule : sld_lcd_driver_test
`default_nettype wire
